// ---- mph_sequencer.sv ----
// Motor preheat sequencer with its AXI4-Lite register slave
`timescale 1ns/1ps
`include "mph_regs.svh"
module mph_sequencer import mph_pkg::*; #(
	parameter logic [31:0] MINUTE_CYCLES = 32'(`MPH_MINUTE_CYCLES)
) (
	input wire logic clk,
	input wire logic nrst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Terminal pins, asynchronous
	input wire logic logic_input_one,
	input wire logic logic_input_three,
	input wire logic logic_input_four,
	// Same-clock control inputs
	input wire logic [15:0] control_word,
	input wire logic operation_enabled,
	input wire logic motor_stopped,
	input wire logic run_order,
	input wire logic stop_order,
	input wire logic two_wire_mode,
	// Outputs to display and firing stage
	output logic heating_active_status,
	output logic [6:0] heating_current_level,
	output logic thermal_monitor_suspend
);

	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic rst_q1; // First reset stage
	logic rst_n; // Released reset used everywhere
	logic [2:0] pin_s1; // First pin stage, read only by pin_s
	logic [2:0] pin_s; // Synchronised pins: one, three, four

	// Reset release through two stages
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// Two-stage pin synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 3'h0;
			pin_s <= 3'h0;
		end else begin
			pin_s1 <= {logic_input_four, logic_input_three, logic_input_one};
			pin_s <= pin_s1;
		end
	end

	// ****************************************
	// Configuration fields
	// ****************************************
	logic [2:0] src; // Request source selector
	logic [2:0] sel; // Line channel bit select
	logic need_di1; // Require input one for pin sources
	logic [6:0] level; // Heating current percent
	logic [9:0] pre_dly; // Preheat delay minutes
	logic [9:0] rst_dly; // Restart delay minutes
	logic reject; // Sticky refused-enable flag

	// Byte-lane mask from strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_mask

	// Clamp a delay to its top value
	function automatic logic [9:0] clamp_dly(input logic [9:0] v);
		clamp_dly = (v > `MPH_DLY_MAX) ? `MPH_DLY_MAX : v;
	endfunction : clamp_dly

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	logic aw_held; // Write address taken
	logic w_held; // Write data taken
	logic [7:0] aw_q; // Latched write address
	logic [31:0] wd_q; // Latched write data
	logic [3:0] ws_q; // Latched strobes
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire [31:0] wmask = lane_mask(ws_q);
	wire hit_ctrl = (aw_q == `MPH_OFS_CTRL);
	wire hit_level = (aw_q == `MPH_OFS_LEVEL);
	wire hit_pre = (aw_q == `MPH_OFS_PRE_DLY);
	wire hit_rst = (aw_q == `MPH_OFS_RST_DLY);
	wire hit_stat = (aw_q == `MPH_OFS_STATUS);
	wire wr_ok = hit_ctrl || hit_level || hit_pre || hit_rst || hit_stat;

	// Current register views merged with write data
	wire [31:0] ctrl_view = {23'h000000, need_di1, 1'b0, sel, 1'b0, src};
	wire [31:0] ctrl_new = (ctrl_view & ~wmask) | (wd_q & wmask);
	wire [31:0] level_new = ({25'h0000000, level} & ~wmask) | (wd_q & wmask);
	wire [31:0] pre_new = ({22'h000000, pre_dly} & ~wmask) | (wd_q & wmask);
	wire [31:0] rst_new = ({22'h000000, rst_dly} & ~wmask) | (wd_q & wmask);
	wire [2:0] src_new = ctrl_new[`MPH_CTRL_SRC_LSB +: 3];
	wire [2:0] sel_raw = ctrl_new[`MPH_CTRL_SEL_LSB +: 3];
	wire refuse = hit_ctrl && two_wire_mode && (src_new != `MPH_SRC_NONE);
	wire clr_reject = hit_stat && wd_q[`MPH_ST_REJECT_BIT] && ws_q[0];

	// Address and data channels, either order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			wd_q <= 32'h00000000;
			ws_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Register updates on a completed write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src <= `MPH_SRC_NONE;
			sel <= 3'h0;
			need_di1 <= 1'b0;
			level <= `MPH_LEVEL_RST;
			pre_dly <= `MPH_PRE_DLY_RST;
			rst_dly <= `MPH_RST_DLY_RST;
		end else if (wr_fire) begin
			if (hit_ctrl) begin
				// Two-wire control keeps the function off
				src <= refuse ? `MPH_SRC_NONE : (src_new > `MPH_SRC_LINE ? src : src_new);
				sel <= (sel_raw > `MPH_LINE_SEL_MAX) ? `MPH_LINE_SEL_MAX : sel_raw;
				need_di1 <= ctrl_new[`MPH_CTRL_DI1_BIT];
			end else if (hit_level) begin
				// Level held inside its percent range
				if (level_new[6:0] < `MPH_LEVEL_MIN || level_new[31:7] != 25'h0000000) begin
					level <= (level_new[31:7] != 25'h0000000) ? `MPH_LEVEL_MAX : `MPH_LEVEL_MIN;
				end else if (level_new[6:0] > `MPH_LEVEL_MAX) begin
					level <= `MPH_LEVEL_MAX;
				end else begin
					level <= level_new[6:0];
				end
			end else if (hit_pre) begin
				pre_dly <= (pre_new[31:10] != 22'h000000) ? `MPH_DLY_MAX : clamp_dly(pre_new[9:0]);
			end else if (hit_rst) begin
				rst_dly <= (rst_new[31:10] != 22'h000000) ? `MPH_DLY_MAX : clamp_dly(rst_new[9:0]);
			end
		end
	end

	// Refused-enable flag, set wins over clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reject <= 1'b0;
		end else if (wr_fire && refuse) begin
			reject <= 1'b1;
		end else if (wr_fire && clr_reject) begin
			reject <= 1'b0;
		end
	end

	// ****************************************
	// Delay timers
	// ****************************************
	logic tick; // Minute pulse
	logic pre_exp; // Preheat delay over
	logic rst_exp; // Restart delay over
	wire assigned = (src != `MPH_SRC_NONE);
	wire [9:0] pre_lim = assigned ? pre_dly : 10'h000;

	// Minute divider
	mph_minute_tick #(.CYCLES(MINUTE_CYCLES)) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	// Preheat delay from last Stop
	mph_delay_timer #(.W(10)) u_pre (
		.clk(clk),
		.rst_n(rst_n),
		.restart(stop_order),
		.tick(tick),
		.limit(pre_lim),
		.expired(pre_exp)
	);

	// Restart delay, same stop event, runs alongside
	mph_delay_timer #(.W(10)) u_rst (
		.clk(clk),
		.rst_n(rst_n),
		.restart(stop_order),
		.tick(tick),
		.limit(rst_dly),
		.expired(rst_exp)
	);

	// ****************************************
	// Request selection and sequencer
	// ****************************************
	mph_state_t state; // Sequencer state
	mph_state_t next_state; // Following state
	wire auto_mode = (src == `MPH_SRC_AUTO);
	wire [4:0] line_idx = `MPH_LINE_BIT_BASE + {2'h0, sel};
	wire line_req = control_word[line_idx[3:0]] && operation_enabled;
	wire pin_req = ((src == `MPH_SRC_IN3) ? pin_s[1] : pin_s[2]) && (!need_di1 || pin_s[0]);
	wire req_ok = assigned && !two_wire_mode && (auto_mode ||
		((src == `MPH_SRC_LINE) ? line_req : pin_req));
	wire delays_ok = pre_exp && rst_exp;
	wire start_ok = motor_stopped && delays_ok && req_ok && !run_order;
	wire end_heat = run_order || !req_ok || !motor_stopped;

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			MPH_WAIT: begin
				if (!stop_order && delays_ok) begin
					next_state = MPH_READY;
				end
			end
			MPH_READY: begin
				if (stop_order) begin
					next_state = MPH_WAIT;
				end else if (start_ok) begin
					next_state = MPH_HEAT;
				end
			end
			MPH_HEAT: begin
				if (stop_order) begin
					next_state = MPH_WAIT;
				end else if (end_heat) begin
					next_state = MPH_READY;
				end
			end
			default: begin
				next_state = MPH_WAIT;
			end
		endcase
	end

	// State and registered outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= MPH_WAIT;
			heating_active_status <= 1'b0;
			thermal_monitor_suspend <= 1'b0;
			heating_current_level <= 7'h00;
		end else begin
			state <= next_state;
			heating_active_status <= (next_state == MPH_HEAT);
			thermal_monitor_suspend <= (next_state == MPH_HEAT);
			heating_current_level <= assigned ? level : 7'h00;
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	logic [31:0] rd_word; // Selected read value
	logic rd_ok; // Address mapped

	// Read decode
	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == `MPH_OFS_CTRL) begin
			rd_word = ctrl_view;
		end else if (s_axi_araddr == `MPH_OFS_LEVEL) begin
			rd_word = {25'h0000000, assigned ? level : 7'h00};
		end else if (s_axi_araddr == `MPH_OFS_PRE_DLY) begin
			rd_word = {22'h000000, pre_lim};
		end else if (s_axi_araddr == `MPH_OFS_RST_DLY) begin
			rd_word = {22'h000000, rst_dly};
		end else if (s_axi_araddr == `MPH_OFS_STATUS) begin
			rd_word = {26'h0000000, reject, motor_stopped, rst_exp, pre_exp, 1'b0,
				heating_active_status};
		end else begin
			rd_word = 32'h00000000;
			rd_ok = 1'b0;
		end
	end

	// Read channel, one outstanding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	start_when_stopped_a: assert property (
		$rose(heating_active_status) |-> $past(motor_stopped))
		else $error("heating started with motor turning");
	start_after_delays_a: assert property (
		$rose(heating_active_status) |-> $past(pre_exp) && $past(rst_exp))
		else $error("heating started before delays expired");
	stop_restarts_delay_a: assert property (
		(stop_order && pre_lim != 10'h000) |=> !pre_exp ##1 !pre_exp)
		else $error("preheat delay not restarted by stop");
	request_low_ends_a: assert property (
		(state == MPH_HEAT && !req_ok) |=> !heating_active_status)
		else $error("heating kept after request dropped");
	run_ends_heat_a: assert property (
		(heating_active_status && run_order) |=> !heating_active_status)
		else $error("heating kept after run order");
	stop_ends_heat_a: assert property (
		stop_order |=> !heating_active_status && state == MPH_WAIT)
		else $error("heating kept after stop order");
	thermal_suspend_a: assert property (
		heating_active_status == thermal_monitor_suspend)
		else $error("thermal suspend out of step with heating");
	line_needs_enable_a: assert property (
		($rose(heating_active_status) && src == `MPH_SRC_LINE) |-> $past(operation_enabled))
		else $error("line request heated without operation enabled");
	level_in_range_a: assert property (
		level >= `MPH_LEVEL_MIN && level <= `MPH_LEVEL_MAX)
		else $error("heating level out of range");
	two_wire_blocks_a: assert property (
		$rose(heating_active_status) |-> !$past(two_wire_mode))
		else $error("heating started under two-wire control");

	heat_start_c: cover property ($rose(heating_active_status));
	run_end_c: cover property (heating_active_status && run_order);
	auto_heat_c: cover property (heating_active_status && auto_mode);
	line_heat_c: cover property (heating_active_status && src == `MPH_SRC_LINE);

endmodule : mph_sequencer

// ---- mph_regs.svh ----
// Register map, field positions, reset values and timing counts of the preheat sequencer
// Operation
// - Start heating only while motor stands still
// - Wait for restart and preheat delays first
// - Preheat delay from last Stop, 0-999 min
// - Both delays run together, longer one wins
// - Request input low ends heating
// - Run order ends heating at once
// - Stop order ends heating
// - Heating status shown once order applied
// - Source: none, input three, four, auto, line
// - Auto source starts without any input
// - Line source uses control word bit 11-15
// - Line source needs operation enabled state
// - Level 5-70 percent, default five
// - Thermal monitoring suspended while heating
// - Level and delay apply only when assigned
// - Auto mode heats when ready, Stop ends
// - Refuse enabling under two-wire control
`ifndef MPH_REGS_SVH
`define MPH_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MPH_OFS_CTRL 8'h00
`define MPH_OFS_LEVEL 8'h04
`define MPH_OFS_PRE_DLY 8'h08
`define MPH_OFS_RST_DLY 8'h0C
`define MPH_OFS_STATUS 8'h10

// ****************************************
// Field positions and encodings
// ****************************************
`define MPH_CTRL_SRC_LSB 0
`define MPH_CTRL_SEL_LSB 4
`define MPH_CTRL_DI1_BIT 8
`define MPH_SRC_NONE 3'h0
`define MPH_SRC_IN3 3'h1
`define MPH_SRC_IN4 3'h2
`define MPH_SRC_AUTO 3'h3
`define MPH_SRC_LINE 3'h4
`define MPH_LINE_BIT_BASE 5'h0B
`define MPH_LINE_SEL_MAX 3'h4
`define MPH_ST_HEAT_BIT 0
`define MPH_ST_PRE_EXP_BIT 2
`define MPH_ST_RST_EXP_BIT 3
`define MPH_ST_STOPPED_BIT 4
`define MPH_ST_REJECT_BIT 5

// ****************************************
// Reset values and limits
// ****************************************
`define MPH_LEVEL_RST 7'h05
`define MPH_LEVEL_MIN 7'h05
`define MPH_LEVEL_MAX 7'h46
`define MPH_PRE_DLY_RST 10'h005
`define MPH_RST_DLY_RST 10'h002
`define MPH_DLY_MAX 10'h3E7

// ****************************************
// Timing
// ****************************************
`define MPH_CLK_HZ 64'd50000000
`define MPH_MINUTE_S 64'd60
`define MPH_MINUTE_CYCLES (`MPH_MINUTE_S * `MPH_CLK_HZ)

`endif

// ---- mph_pkg.sv ----
// Types shared by the preheat sequencer modules
package mph_pkg;

	// Sequencer states
	typedef enum logic [1:0] {
		MPH_WAIT,
		MPH_READY,
		MPH_HEAT
	} mph_state_t;

endpackage : mph_pkg

// ---- mph_minute_tick.sv ----
// Divider giving a one-cycle pulse every minute
`timescale 1ns/1ps
module mph_minute_tick import mph_pkg::*; #(
	parameter logic [31:0] CYCLES = 32'd3000000000
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);

	// Cycle counter within the current minute
	logic [31:0] cnt;
	wire last = (cnt == CYCLES - 32'h00000001);

	// ****************************************
	// Count and pulse
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h00000000;
			tick <= 1'b0;
		end else begin
			cnt <= last ? 32'h00000000 : cnt + 32'h00000001;
			tick <= last;
		end
	end

endmodule : mph_minute_tick

// ---- mph_delay_timer.sv ----
// Minute-resolution delay counter restarted by each stop event
`timescale 1ns/1ps
module mph_delay_timer import mph_pkg::*; #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic tick,
	input wire logic [W-1:0] limit,
	output logic expired
);

	// Minutes since the last stop event
	logic [W-1:0] cnt;
	wire done = (cnt >= limit);

	// Restart wins over counting; holds once done
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (restart) begin
			cnt <= '0;
		end else if (tick && !done) begin
			cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Expiry flag, low again right after a restart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expired <= 1'b0;
		end else begin
			expired <= !restart && done;
		end
	end

endmodule : mph_delay_timer

// ---- mph_far_side.sv ----
// Far-side model: input terminals, fieldbus master and motor of the preheat sequencer
`timescale 1ns/1ps
module mph_far_side (
	input wire logic clk,
	output logic logic_input_one,
	output logic logic_input_three,
	output logic logic_input_four,
	output logic [15:0] control_word,
	output logic operation_enabled,
	output logic motor_stopped,
	output logic run_order,
	output logic stop_order,
	output logic two_wire_mode
);
	// ****************************************
	// Idle levels
	// ****************************************
	// Everything quiet, motor at standstill
	initial begin
		logic_input_one = 1'b0;
		logic_input_three = 1'b0;
		logic_input_four = 1'b0;
		control_word = 16'h0000;
		operation_enabled = 1'b0;
		motor_stopped = 1'b1;
		run_order = 1'b0;
		stop_order = 1'b0;
		two_wire_mode = 1'b0;
	end

	// ****************************************
	// Commands, each called just after a rising edge
	// ****************************************
	// Terminal levels held until the next call
	task automatic set_pins(input logic one, input logic three, input logic four);
		logic_input_one <= one;
		logic_input_three <= three;
		logic_input_four <= four;
	endtask : set_pins
	// Fieldbus word and drive state, held as levels
	task automatic set_line(input logic [15:0] cw, input logic oe);
		control_word <= cw;
		operation_enabled <= oe;
	endtask : set_line
	// Wiring scheme
	task automatic set_two_wire(input logic tw);
		two_wire_mode <= tw;
	endtask : set_two_wire
	// Motor standstill level
	task automatic set_stopped(input logic s);
		motor_stopped <= s;
	endtask : set_stopped
	// Stop order: one-cycle pulse, motor coasts to standstill
	task automatic stop_pulse();
		stop_order <= 1'b1;
		motor_stopped <= 1'b1;
		@(posedge clk);
		stop_order <= 1'b0;
	endtask : stop_pulse
	// Run order: one-cycle pulse, motor starts turning
	task automatic run_pulse();
		run_order <= 1'b1;
		motor_stopped <= 1'b0;
		@(posedge clk);
		run_order <= 1'b0;
	endtask : run_pulse
endmodule : mph_far_side

// ---- tb_top.sv ----
// Self-checking testbench of the preheat sequencer
`timescale 1ns/1ps
`include "mph_regs.svh"
module tb_top;
	// ****************************************
	// Signals
	// ****************************************
	logic clk, nrst;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic in1, in3, in4, oe, stopped, run_o, stop_o, two_wire;
	logic [15:0] cw;
	logic heat, therm;
	logic [6:0] level;
	int num_errors = 0;
	int compares = 0;

	// Short minute so delays take tens of cycles
	mph_sequencer #(.MINUTE_CYCLES(32'd10)) mph_sequencer_i (.clk(clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .logic_input_one(in1),
		.logic_input_three(in3), .logic_input_four(in4), .control_word(cw),
		.operation_enabled(oe), .motor_stopped(stopped), .run_order(run_o),
		.stop_order(stop_o), .two_wire_mode(two_wire), .heating_active_status(heat),
		.heating_current_level(level), .thermal_monitor_suspend(therm));
	// Far side model
	mph_far_side mph_far_side_i (.clk(clk), .logic_input_one(in1), .logic_input_three(in3),
		.logic_input_four(in4), .control_word(cw), .operation_enabled(oe),
		.motor_stopped(stopped), .run_order(run_o), .stop_order(stop_o),
		.two_wire_mode(two_wire));

	// ****************************************
	// Clock, bus idle, watchdog
	// ****************************************
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Bus idle at time zero
	initial begin
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
	end
	// Hang guard
	initial begin
		#400000;
		num_errors++;
		conclude();
	end

	// ****************************************
	// Helpers
	// ****************************************
	// Count and report one comparison
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Counts and verdict
	task automatic conclude();
		$display("Errors %0d, comparisons %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// AXI4-Lite write, returns bresp; bready stays high, watchdog bounds the waits
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge clk);
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask : wr
	// AXI4-Lite read; rready stays high, arvalid dropped once taken
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask : rdr
	// Wait a bounded time for the heating status level, then compare
	task automatic wait_heat(input logic exp, input int max);
		int n;
		n = 0;
		while (heat !== exp && n < max) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, heat}, {31'h0, exp});
	endtask : wait_heat

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		cyc(2);
		nrst <= 1'b1;
		cyc(3);
		// Reset values and unmapped places
		rdr(`MPH_OFS_LEVEL, rd, rs); check(rd, 32'h0);
		rdr(`MPH_OFS_PRE_DLY, rd, rs); check(rd, 32'h0);
		rdr(`MPH_OFS_RST_DLY, rd, rs); check(rd, 32'h2);
		rdr(8'h14, rd, rs);
		check(rd, 32'h0);
		check({30'h0, rs}, 32'h2);
		wr(8'h20, 32'h1, rs);
		check({30'h0, rs}, 32'h2);
		// Enabling under two-wire control is refused
		mph_far_side_i.set_two_wire(1'b1);
		wr(`MPH_OFS_CTRL, 32'h1, rs);
		rdr(`MPH_OFS_CTRL, rd, rs); check(rd & 32'h7, 32'h0);
		rdr(`MPH_OFS_STATUS, rd, rs); check(rd & 32'h20, 32'h20);
		wr(`MPH_OFS_STATUS, 32'h20, rs);
		rdr(`MPH_OFS_STATUS, rd, rs);
		check(rd & 32'h20, 32'h0);
		mph_far_side_i.set_two_wire(1'b0);
		// Input three with input one; level and delay now visible
		wr(`MPH_OFS_CTRL, 32'h101, rs);
		rdr(`MPH_OFS_LEVEL, rd, rs); check(rd, 32'h5);
		rdr(`MPH_OFS_PRE_DLY, rd, rs); check(rd, 32'h5);
		wr(`MPH_OFS_LEVEL, 32'h64, rs);
		rdr(`MPH_OFS_LEVEL, rd, rs); check(rd, 32'h46);
		wr(`MPH_OFS_LEVEL, 32'h2, rs);
		rdr(`MPH_OFS_LEVEL, rd, rs); check(rd, 32'h5);
		wr(`MPH_OFS_LEVEL, 32'h21, rs);
		wr(`MPH_OFS_RST_DLY, 32'h7, rs);
		// Restart delay longer than preheat delay: the longer one governs
		mph_far_side_i.set_pins(1'b1, 1'b1, 1'b0);
		mph_far_side_i.stop_pulse();
		cyc(55);
		check({31'h0, heat}, 32'h0);
		wait_heat(1'b1, 25);
		check({31'h0, therm}, 32'h1);
		check({25'h0, level}, 32'h21);
		// Request low ends heating, input one is required
		mph_far_side_i.set_pins(1'b1, 1'b0, 1'b0);
		wait_heat(1'b0, 8);
		check({31'h0, therm}, 32'h0);
		mph_far_side_i.set_pins(1'b0, 1'b1, 1'b0);
		cyc(10);
		check({31'h0, heat}, 32'h0);
		mph_far_side_i.set_pins(1'b1, 1'b1, 1'b0);
		wait_heat(1'b1, 10);
		// Run order ends heating; no start while turning
		mph_far_side_i.run_pulse();
		wait_heat(1'b0, 3);
		cyc(20);
		check({31'h0, heat}, 32'h0);
		mph_far_side_i.set_stopped(1'b1);
		wait_heat(1'b1, 10);
		// Stop order ends heating and restarts both delays
		mph_far_side_i.stop_pulse();
		wait_heat(1'b0, 3);
		cyc(30);
		check({31'h0, heat}, 32'h0);
		// Input four source
		wr(`MPH_OFS_CTRL, 32'h2, rs);
		mph_far_side_i.set_pins(1'b0, 1'b0, 1'b1);
		wait_heat(1'b1, 120);
		// Automatic source heats with no input and holds it, Stop ends it
		mph_far_side_i.set_pins(1'b0, 1'b0, 1'b0);
		wr(`MPH_OFS_CTRL, 32'h3, rs);
		mph_far_side_i.stop_pulse();
		wait_heat(1'b0, 3);
		wait_heat(1'b1, 120);
		cyc(20);
		check({31'h0, heat}, 32'h1);
		mph_far_side_i.stop_pulse();
		wait_heat(1'b0, 3);
		// Line source on control word bit 13, needs operation enabled
		wr(`MPH_OFS_CTRL, 32'h24, rs);
		mph_far_side_i.set_line(16'h1000, 1'b1);
		mph_far_side_i.stop_pulse();
		cyc(100);
		check({31'h0, heat}, 32'h0);
		mph_far_side_i.set_line(16'h2000, 1'b0);
		cyc(6);
		check({31'h0, heat}, 32'h0);
		mph_far_side_i.set_line(16'h2000, 1'b1);
		wait_heat(1'b1, 6);
		// Source withdrawn: heating stops, level output cleared
		wr(`MPH_OFS_CTRL, 32'h0, rs);
		wait_heat(1'b0, 6);
		cyc(2);
		check({25'h0, level}, 32'h0);
		conclude();
	end
endmodule : tb_top
